// file: sim/attach_detector.sv
/*
 * model of the external attach and orientation detector.
 * assumes the bench requests plug, flip, polarity and mode levels.
 */
`timescale 1ns/100ps
module attach_detector #(
   parameter int N = 2
) (
   input wire logic aclk,
   input wire logic [N-1:0] plugged,
   input wire logic [N-1:0] flipped,
   input wire logic pol,
   input wire logic mode,
   output logic [N-1:0] attach = '0,
   output logic [N-1:0] orient = '0,
   output logic [N-1:0] oa = '0,
   output logic [N-1:0] ob = '0,
   output logic pol_strap = 1'b0,
   output logic mode_strap = 1'b0
);
   logic t = 1'b0;
   // unused scheme lines toggle so that ignoring them is visible
   always_ff @(posedge aclk) begin
      t <= !t;
      pol_strap <= pol;
      mode_strap <= mode;
      attach <= mode ? {N{t}} : plugged ^ {N{pol}};
      orient <= mode ? {N{t}} : flipped ^ {N{pol}};
      oa <= mode ? (plugged & ~flipped) ^ {N{pol}} : {N{t}};
      ob <= mode ? (plugged & flipped) ^ {N{pol}} : {N{t}};
   end
endmodule

// file: sim/attach_enable_checker.sv
/*
 * lane enable checks, bound to the top module.
 * assumes pins reach the lanes three edges after they are sampled.
 */
`timescale 1ns/100ps
module attach_enable_checker
   import attach_enable_pkg::*;
#(
   parameter int NPORTS = PORT_COUNT
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [NPORTS-1:0] connector_attach_in,
   input wire logic [NPORTS-1:0] orientation_select_in,
   input wire logic [NPORTS-1:0] orient_a_attach_in,
   input wire logic [NPORTS-1:0] orient_b_attach_in,
   input wire logic attach_polarity_strap,
   input wire logic control_mode_strap,
   input wire logic [NPORTS-1:0] lane_a_enable,
   input wire logic [NPORTS-1:0] lane_b_enable,
   input wire logic s_axi_bvalid,
   input wire logic [1:0] s_axi_bresp
);
   localparam int N = NPORTS;
   logic [4*N+1:0] pins;
   logic [4*N+1:0] p3;
   logic m3;
   logic pol3;
   logic lg3;
   logic [N-1:0] at3, or3, oa3, ob3;
   assign pins = {control_mode_strap, attach_polarity_strap,
      connector_attach_in, orientation_select_in, orient_a_attach_in,
      orient_b_attach_in};
   // pins as seen three edges back
   always_ff @(posedge aclk) p3 <= $past(pins, 2);
   assign m3 = p3[4*N+1];
   assign pol3 = p3[4*N];
   assign at3 = p3[4*N-1:3*N] ^ {N{pol3}};
   assign or3 = p3[3*N-1:2*N] ^ {N{pol3}};
   assign oa3 = p3[2*N-1:N] ^ {N{pol3}};
   assign ob3 = p3[N-1:0] ^ {N{pol3}};
   assign lg3 = !m3 && !pol3 && (&p3[4*N-1:3*N]);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_m1_lane_a: assert property (!m3 && !lg3
      |-> (lane_a_enable & ~(at3 & ~or3)) == '0) else $error("bad lane a");
   a_m1_lane_b: assert property (!m3 && !lg3
      |-> (lane_b_enable & ~(at3 & or3)) == '0) else $error("bad lane b");
   a_detach_off: assert property (!m3
      |-> ((lane_a_enable | lane_b_enable) & ~at3) == '0)
      else $error("lane on while detached");
   a_one_lane: assert property (!m3 && !lg3
      |-> (lane_a_enable & lane_b_enable) == '0) else $error("two lanes on");
   a_m2_lane_a: assert property (m3
      |-> (lane_a_enable & ~oa3) == '0) else $error("bad mode 2 lane a");
   a_m2_lane_b: assert property (m3
      |-> (lane_b_enable & ~ob3) == '0) else $error("bad mode 2 lane b");
   a_legacy_on: assert property (lg3
      |-> (lane_a_enable & lane_b_enable) == '1) else $error("legacy off");
   a_sync_delay: assert property ($past(aresetn, 4) &&
      (lane_a_enable != $past(lane_a_enable) ||
      lane_b_enable != $past(lane_b_enable)) |-> p3 != $past(p3))
      else $error("lane change without pin change");
   c_both: cover property (lane_a_enable != '0 && lane_b_enable != '0);
   c_mode2_b: cover property (m3 && lane_b_enable != '0);
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

// file: sim/reversible_attach_phy_enable_tb.sv
/*
 * testbench: pins through the detector model, registers over axi4-lite.
 * assumes the design and checker are compiled before it.
 */
`timescale 1ns/100ps
module reversible_attach_phy_enable_tb;
   import attach_enable_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [1:0] plugged = '0, flipped = '0;
   logic pol = 1'b0, mode = 1'b0, pol_s, mode_s;
   logic [1:0] att, ori, oa, ob, lane_a, lane_b, bresp, rresp, rs, ea, eb;
   logic [7:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, rd;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, lg;
   int num_errors = 0, cmp_count = 0, cyc = 0;
   always #5 aclk = ~aclk;
   attach_detector #(.N(2)) u_attach_detector (.aclk(aclk),
      .plugged(plugged), .flipped(flipped), .pol(pol), .mode(mode),
      .attach(att), .orient(ori), .oa(oa), .ob(ob), .pol_strap(pol_s),
      .mode_strap(mode_s));
   reversible_attach_phy_enable u_reversible_attach_phy_enable (
      .aclk(aclk), .aresetn(aresetn), .connector_attach_in(att),
      .orientation_select_in(ori), .orient_a_attach_in(oa),
      .orient_b_attach_in(ob), .attach_polarity_strap(pol_s),
      .control_mode_strap(mode_s), .lane_a_enable(lane_a),
      .lane_b_enable(lane_b), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         output logic [1:0] r);
      logic ha, hw, hb;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(negedge aclk);
         ha = awready;
         hw = wready;
         hb = bvalid;
         r = bresp;
         @(posedge aclk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         if (hb) break;
      end
      bready <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d,
         output logic [1:0] r);
      logic ha, hr;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(negedge aclk);
         ha = arready;
         hr = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ha) arvalid <= 1'b0;
         if (hr) break;
      end
      rready <= 1'b0;
   endtask
   task automatic settle;
      repeat (7) @(posedge aclk);
      @(negedge aclk);
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         end_sim();
      end
   end
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd_reg(CONTROL_OFFSET, rd, rs);
      check(rd, CONTROL_RESET);
      check({30'h0, rs}, {30'h0, RESP_OKAY});
      for (int i = 0; i < 64; i++) begin
         @(posedge aclk);
         {mode, pol, plugged, flipped} <= i[5:0];
         settle();
         lg = !i[5] && !i[4] && (i[3:2] == 2'b11);
         ea = lg ? 2'b11 : i[3:2] & ~i[1:0];
         eb = lg ? 2'b11 : i[3:2] & i[1:0];
         check({30'h0, lane_a}, {30'h0, ea});
         check({30'h0, lane_b}, {30'h0, eb});
         rd_reg(STATUS_OFFSET, rd, rs);
         check(rd, {13'h0, lg, i[4], i[5], 6'h0, eb, 6'h0, ea});
      end
      $display("test decode done");
      pol <= 1'b1;
      mode <= 1'b0;
      plugged <= 2'b00;
      wr(CONTROL_OFFSET, 32'hffff_0201, rs);
      check({30'h0, rs}, {30'h0, RESP_OKAY});
      rd_reg(CONTROL_OFFSET, rd, rs);
      check(rd, 32'h0000_0201);
      check({30'h0, rs}, {30'h0, RESP_OKAY});
      plugged <= 2'b11;
      flipped <= 2'b10;
      settle();
      check({28'h0, lane_b, lane_a}, 32'h0);
      @(posedge aclk);
      flipped <= 2'b01;
      settle();
      check({28'h0, lane_b, lane_a}, 32'h6);
      @(posedge aclk);
      plugged <= 2'b00;
      settle();
      rd_reg(PIN_LEVEL_OFFSET, rd, rs);
      check(rd & 32'h0000_ffff, 32'h0000_0203);
      check({30'h0, rs}, {30'h0, RESP_OKAY});
      wr(CONTROL_OFFSET, 32'h0, rs);
      wstrb <= 4'h2;
      wr(CONTROL_OFFSET, 32'h0000_0303, rs);
      wstrb <= 4'hf;
      rd_reg(CONTROL_OFFSET, rd, rs);
      check(rd, 32'h0000_0300);
      wr(CONTROL_OFFSET, 32'h0, rs);
      wr(8'h10, 32'h1, rs);
      check({30'h0, rs}, {30'h0, RESP_SLVERR});
      wr(STATUS_OFFSET, 32'hffff_ffff, rs);
      check({30'h0, rs}, {30'h0, RESP_OKAY});
      rd_reg(8'h10, rd, rs);
      check(rd, 32'h0);
      check({30'h0, rs}, {30'h0, RESP_SLVERR});
      $display("test register done");
      end_sim();
   end
endmodule
bind reversible_attach_phy_enable attach_enable_checker #(.NPORTS(NPORTS))
   u_attach_enable_checker (.aclk(aclk), .aresetn(aresetn),
   .connector_attach_in(connector_attach_in),
   .orientation_select_in(orientation_select_in),
   .orient_a_attach_in(orient_a_attach_in),
   .orient_b_attach_in(orient_b_attach_in),
   .attach_polarity_strap(attach_polarity_strap),
   .control_mode_strap(control_mode_strap), .lane_a_enable(lane_a_enable),
   .lane_b_enable(lane_b_enable), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bresp(s_axi_bresp));

// file: verilog/attach_enable_pkg.sv
/*
 * constants for the reversible-connector lane enable block: port count,
 * register offsets, field positions and reset values.
 * assumes a 32-bit axi4-lite register bus with byte addresses.
 */
package attach_enable_pkg;
   localparam int PORT_COUNT = 2;
   localparam int ADDR_WIDTH = 8;
   localparam int DATA_WIDTH = 32;

   // register byte offsets
   localparam logic [7:0] CONTROL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] PIN_LEVEL_OFFSET = 8'h08;

   // control: lane disable masks
   localparam int CTRL_MASK_A_LSB = 0;
   localparam int CTRL_MASK_B_LSB = 8;
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
   localparam logic [31:0] CONTROL_WRITE_MASK = 32'h0000_ffff;

   // status: lane enables and straps
   localparam int STAT_EN_A_LSB = 0;
   localparam int STAT_EN_B_LSB = 8;
   localparam int STAT_MODE_BIT = 16;
   localparam int STAT_POL_BIT = 17;
   localparam int STAT_LEGACY_BIT = 18;

   // pin level: synchronised raw inputs
   localparam int PIN_ATTACH_LSB = 0;
   localparam int PIN_ORIENT_LSB = 8;
   localparam int PIN_ORIENT_A_LSB = 16;
   localparam int PIN_ORIENT_B_LSB = 24;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] SYNC_RESET = 2'h0;
endpackage

// file: verilog/level_sync.sv
/*
 * two-flop synchroniser for a vector of independent levels.
 * assumes each bit is a slow level; no bus coherency between bits.
 */
`timescale 1ns/100ps
module level_sync
   import attach_enable_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_state_type;

   sync_state_type state_q;
   sync_state_type state_d;

   always_comb begin
      state_d = state_q;
      state_d.meta = async_in;
      state_d.stable = state_q.meta;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign sync_out = state_q.stable;
endmodule

// file: verilog/reversible_attach_phy_enable.sv
/*
 * attach and orientation decode for the superspeed lanes (orientation a
 * and b) of the reversible-connector ports, with an axi4-lite register
 * window for lane masking and status.
 * assumes all pins are asynchronous and are synchronised here; aclk is
 * the hub core clock, aresetn the synchronous hub reset.
 */
// How it works
// - mode 1: attach input reporting attach enables that port's lanes.
// - mode 1: attach reporting no connection keeps that port's lanes off.
// - polarity strap low: attach 1 means attached; strap high: 0 means it.
// - strap low: orientation 1 picks lane b; strap high: 1 picks lane a.
// - mode 1: chosen lane is enabled only while attach is asserted.
// - mode 1, polarity strap low: all attach inputs held high for legacy connectors: every lane on.
// - mode 2: orientation-a attach asserted enables lane a.
// - mode 2: orientation-a attach deasserted disables lane a.
// - mode 2 attach inputs use the same polarity strap.
// - mode strap low: mode 1, per-orientation attach inputs ignored.
`timescale 1ns/100ps
module reversible_attach_phy_enable
   import attach_enable_pkg::*;
#(
   parameter int NPORTS = PORT_COUNT
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [NPORTS-1:0] connector_attach_in,
   input wire logic [NPORTS-1:0] orientation_select_in,
   input wire logic [NPORTS-1:0] orient_a_attach_in,
   input wire logic [NPORTS-1:0] orient_b_attach_in,
   input wire logic attach_polarity_strap,
   input wire logic control_mode_strap,
   output logic [NPORTS-1:0] lane_a_enable,
   output logic [NPORTS-1:0] lane_b_enable,
   input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_WIDTH-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_WIDTH-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int SYNC_W = 4 * NPORTS + 2;

   typedef struct packed {
      logic aw_full;
      logic [ADDR_WIDTH-1:0] aw_addr;
      logic w_full;
      logic [DATA_WIDTH-1:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [DATA_WIDTH-1:0] rdata;
      logic [DATA_WIDTH-1:0] control;
      logic legacy;
      logic [NPORTS-1:0] en_a;
      logic [NPORTS-1:0] en_b;
   } state_type;

   state_type state_q;
   state_type state_d;
   logic [SYNC_W-1:0] pins_sync;
   logic pol;
   logic mode2;
   logic [NPORTS-1:0] att_raw;
   logic [NPORTS-1:0] ori_raw;
   logic [NPORTS-1:0] oa_raw;
   logic [NPORTS-1:0] ob_raw;
   logic [NPORTS-1:0] attached;
   logic [NPORTS-1:0] pick_b;
   logic [NPORTS-1:0] mask_a;
   logic [NPORTS-1:0] mask_b;
   logic [DATA_WIDTH-1:0] status_word;
   logic [DATA_WIDTH-1:0] pin_word;

   // every pin crosses two flops before decode
   level_sync #(
      .WIDTH(SYNC_W)
   ) pin_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in({orient_b_attach_in, orient_a_attach_in,
                 orientation_select_in, connector_attach_in,
                 control_mode_strap, attach_polarity_strap}),
      .sync_out(pins_sync)
   );

   assign pol = pins_sync[0];
   assign mode2 = pins_sync[1];
   assign att_raw = pins_sync[2 +: NPORTS];
   assign ori_raw = pins_sync[2 + NPORTS +: NPORTS];
   assign oa_raw = pins_sync[2 + 2 * NPORTS +: NPORTS];
   assign ob_raw = pins_sync[2 + 3 * NPORTS +: NPORTS];
   assign mask_a = state_q.control[CTRL_MASK_A_LSB +: NPORTS];
   assign mask_b = state_q.control[CTRL_MASK_B_LSB +: NPORTS];

   always_comb begin
      status_word = '0;
      status_word[STAT_EN_A_LSB +: NPORTS] = state_q.en_a;
      status_word[STAT_EN_B_LSB +: NPORTS] = state_q.en_b;
      status_word[STAT_MODE_BIT] = mode2;
      status_word[STAT_POL_BIT] = pol;
      status_word[STAT_LEGACY_BIT] = state_q.legacy;
      pin_word = '0;
      pin_word[PIN_ATTACH_LSB +: NPORTS] = att_raw;
      pin_word[PIN_ORIENT_LSB +: NPORTS] = ori_raw;
      pin_word[PIN_ORIENT_A_LSB +: NPORTS] = oa_raw;
      pin_word[PIN_ORIENT_B_LSB +: NPORTS] = ob_raw;
   end

   always_comb begin
      state_d = state_q;

      // lane decode
      attached = att_raw ^ {NPORTS{pol}};
      pick_b = ori_raw ^ {NPORTS{pol}};
      // all-on only for active-high straps in mode 1
      state_d.legacy = (&att_raw) & ~pol & ~mode2;
      if (mode2) begin
         // orientation attach lines, same polarity strap
         state_d.en_a = (oa_raw ^ {NPORTS{pol}}) & ~mask_a;
         state_d.en_b = (ob_raw ^ {NPORTS{pol}}) & ~mask_b;
      end else if (state_d.legacy) begin
         state_d.en_a = ~mask_a;
         state_d.en_b = ~mask_b;
      end else begin
         // orient_a/b lines unused in mode 1
         state_d.en_a = attached & ~pick_b & ~mask_a;
         state_d.en_b = attached & pick_b & ~mask_b;
      end

      // write channel: address and data taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         state_d.aw_full = 1'b1;
         state_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         state_d.w_full = 1'b1;
         state_d.w_data = s_axi_wdata;
         state_d.w_strb = s_axi_wstrb;
      end
      // a pair taken while bvalid stands waits here for bready
      if (state_q.aw_full && state_q.w_full && !state_q.bvalid) begin
         state_d.aw_full = 1'b0;
         state_d.w_full = 1'b0;
         state_d.bvalid = 1'b1;
         if (state_q.aw_addr[7:2] == CONTROL_OFFSET[7:2]) begin
            for (int i = 0; i < 4; i++) begin
               if (state_q.w_strb[i]) begin
                  state_d.control[8*i +: 8] = state_q.w_data[8*i +: 8];
               end
            end
            state_d.control = state_d.control & CONTROL_WRITE_MASK;
            state_d.bresp = RESP_OKAY;
         end else if (state_q.aw_addr[7:2] == STATUS_OFFSET[7:2] ||
                      state_q.aw_addr[7:2] == PIN_LEVEL_OFFSET[7:2]) begin
            state_d.bresp = RESP_OKAY;
         end else begin
            state_d.bresp = RESP_SLVERR;
         end
      end
      if (state_q.bvalid && s_axi_bready) begin
         state_d.bvalid = 1'b0;
      end

      // read channel
      if (s_axi_arvalid && s_axi_arready) begin
         state_d.rvalid = 1'b1;
         state_d.rresp = RESP_OKAY;
         if (s_axi_araddr[7:2] == CONTROL_OFFSET[7:2]) begin
            state_d.rdata = state_q.control;
         end else if (s_axi_araddr[7:2] == STATUS_OFFSET[7:2]) begin
            state_d.rdata = status_word;
         end else if (s_axi_araddr[7:2] == PIN_LEVEL_OFFSET[7:2]) begin
            state_d.rdata = pin_word;
         end else begin
            state_d.rdata = '0;
            state_d.rresp = RESP_SLVERR;
         end
      end else if (state_q.rvalid && s_axi_rready) begin
         state_d.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= '0;
         state_q.control <= CONTROL_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   assign s_axi_awready = !state_q.aw_full;
   assign s_axi_wready = !state_q.w_full;
   assign s_axi_bvalid = state_q.bvalid;
   assign s_axi_bresp = state_q.bresp;
   // one read in flight; next address waits for rready
   assign s_axi_arready = !state_q.rvalid;
   assign s_axi_rvalid = state_q.rvalid;
   assign s_axi_rresp = state_q.rresp;
   assign s_axi_rdata = state_q.rdata;
   assign lane_a_enable = state_q.en_a;
   assign lane_b_enable = state_q.en_b;
endmodule
